// ===== rtl/smc_pkg.sv
package smc_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [1:0] ADR_PWR_CTRL  = 2'h0;
    localparam logic [1:0] ADR_PWR_GATES = 2'h1;
    localparam logic [1:0] ADR_STATUS    = 2'h2;

    localparam int BIT_SLEEP_ARM    = 5;
    localparam int BIT_SLEEP_SEL_HI = 4;
    localparam int BIT_SLEEP_SEL_LO = 3;
    localparam int BIT_PULLUP_DIS   = 6;
    localparam logic [7:0] PWR_CTRL_MASK = 8'hfb;
    localparam logic [7:0] PWR_CTRL_RST  = 8'h00;

    localparam int BIT_GATE_TIMER_B = 3;
    localparam int BIT_GATE_TIMER_A = 2;
    localparam int BIT_GATE_SERIAL  = 1;
    localparam int BIT_GATE_CONV    = 0;
    localparam logic [7:0] GATES_MASK = 8'h0f;
    localparam logic [7:0] GATES_RST  = 8'h00;

    // ---------------------------------------------------------------
    // sleep modes and timing
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_IDLE    = 2'h0;
    localparam logic [1:0] SEL_NOISE   = 2'h1;
    localparam logic [1:0] SEL_PDOWN   = 2'h2;
    localparam logic [1:0] SEL_STANDBY = 2'h3;

    localparam int WAKE_HALT_CYCLES    = 4;
    localparam int STANDBY_WAKE_CYCLES = 6;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_START,
        ST_HALT
    } smc_state_t;

    typedef struct packed {
        logic adc_done;
        logic spm_ready;
        logic ext_irq_zero_lvl;
        logic ext_irq_zero_edge;
        logic pin_change;
        logic wdt_irq;
        logic other_io;
    } smc_wake_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic osc;
    } smc_clk_t;

endpackage

// ===== rtl/smc_sleep_ctrl.sv
// Contract
// - mode 01 enters noise reduction, adc clock runs
// - noise entry with adc enabled starts conversion
// - noise mode wakes on its listed sources
// - mode 10 enters power-down, oscillator stops
// - power-down wakes on resets, level irq, pin-change
// - mode 11 with crystal enters standby
// - standby resumes core clock within six cycles
// - gate bit stops clock; timer a gate also blocks register access
// - clearing gate bit resumes frozen peripheral state
// - gating applies in active and idle modes
// - adc stays enabled asleep; re-enable means extended
// - deep sleep disables comparator unless bandgap used
// - fused brown-out detector stays on asleep
// - enabled watchdog keeps running asleep
// - io and adc stopped disables input buffers
// - sleep only when arm bit five set
// - select bits 4:3 encode four modes
// - reserved bit 2 reads zero, resets zero
// - gate bits 3,2,1 timer b, a, serial
// - gated adc mux unavailable to comparator
// - mode 00 enters idle, halts cpu and flash
// - core halted four cycles after start-up
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int START_CYCLES = 16
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RSTN,
    input  wire logic [1:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       SLEEP_REQ,
    input  wire smc_wake_t  WAKE,
    input  wire logic       XTAL_SEL,
    input  wire logic       ADC_EN,
    input  wire logic       ACMP_BANDGAP,
    input  wire logic       BOD_FUSE,
    input  wire logic       WDT_EN,
    output smc_clk_t        CLK_EN,
    output logic            TIMER_A_CLK_EN,
    output logic            TIMER_B_CLK_EN,
    output logic            SERIAL_CLK_EN,
    output logic            ADC_CLK_EN,
    output logic            PERIPH_ACC_BLOCK_T_A,
    output logic            ADC_AUTO_START,
    output logic            ADC_EXTENDED,
    output logic            ACMP_DISABLE,
    output logic            ACMP_MUX_BLOCK,
    output logic            BOD_ON,
    output logic            WDT_RUN,
    output logic            INBUF_DISABLE,
    output logic            PULLUP_DISABLE,
    output logic            CORE_RUN,
    output logic            IRQ_SERVICE
);

    // ---------------------------------------------------------------
    // wake input synchroniser
    // ---------------------------------------------------------------
    smc_wake_t wake_s1_q;
    smc_wake_t wake_s2_q;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            wake_s1_q <= '0;
            wake_s2_q <= '0;
        end else begin
            wake_s1_q <= WAKE;
            wake_s2_q <= wake_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] gates_q;
    logic [7:0] rdata_q;
    logic [1:0] mode_q;
    smc_state_t state_q;
    logic [3:0] cnt_q;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ctrl_q <= PWR_CTRL_RST;
        end else if (WR && ADDR == ADR_PWR_CTRL) begin
            ctrl_q <= WDATA & PWR_CTRL_MASK;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            gates_q <= GATES_RST;
        end else if (WR && ADDR == ADR_PWR_GATES) begin
            gates_q <= WDATA & GATES_MASK;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                ADR_PWR_CTRL:  rdata_q <= ctrl_q;
                ADR_PWR_GATES: rdata_q <= gates_q;
                ADR_STATUS:    rdata_q <= {3'h0, mode_q, 3'(state_q)};
                default:       rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // sleep sequencer
    // ---------------------------------------------------------------
    function automatic logic wake_ok(input logic [1:0] m, input smc_wake_t w);
        case (m)
            SEL_IDLE:  wake_ok = |w;
            SEL_NOISE: wake_ok = w.adc_done | w.spm_ready | w.ext_irq_zero_lvl
                                 | w.pin_change | w.wdt_irq;
            default:   wake_ok = w.ext_irq_zero_lvl | w.pin_change
                                 | w.wdt_irq;
        endcase
    endfunction

    logic armed;
    logic [1:0] sel;
    assign sel   = ctrl_q[BIT_SLEEP_SEL_HI:BIT_SLEEP_SEL_LO];
    assign armed = SLEEP_REQ && ctrl_q[BIT_SLEEP_ARM]
                   && !(sel == SEL_STANDBY && !XTAL_SEL);

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state_q <= ST_ACTIVE;
            mode_q  <= SEL_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            case (state_q)
                ST_ACTIVE: begin
                    if (armed) begin
                        state_q <= ST_SLEEP;
                        mode_q  <= sel;
                    end
                end
                ST_SLEEP: begin
                    if (wake_ok(mode_q, wake_s2_q)) begin
                        state_q <= ST_START;
                        cnt_q   <= 4'h0;
                    end
                end
                ST_START: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (mode_q != SEL_PDOWN || cnt_q == 4'(START_CYCLES - 1)) begin
                        state_q <= ST_HALT;
                        cnt_q   <= 4'h0;
                    end
                end
                ST_HALT: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(WAKE_HALT_CYCLES - 1)) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                default: state_q <= ST_ACTIVE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // clock and power outputs
    // ---------------------------------------------------------------
    logic asleep;
    logic deep;
    assign asleep = state_q == ST_SLEEP;
    assign deep   = asleep && mode_q[1];

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            CLK_EN <= '1;
        end else begin
            CLK_EN.cpu   <= !asleep && state_q != ST_START;
            CLK_EN.flash <= !asleep;
            CLK_EN.io    <= !(asleep && mode_q != SEL_IDLE);
            CLK_EN.adc   <= !deep;
            CLK_EN.osc   <= !(asleep && mode_q == SEL_PDOWN);
        end
    end

    logic idle_or_active;
    assign idle_or_active = !asleep || mode_q == SEL_IDLE;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            TIMER_A_CLK_EN       <= 1'b1;
            TIMER_B_CLK_EN       <= 1'b1;
            SERIAL_CLK_EN        <= 1'b1;
            ADC_CLK_EN           <= 1'b1;
            PERIPH_ACC_BLOCK_T_A <= 1'b0;
            ACMP_MUX_BLOCK       <= 1'b0;
        end else begin
            TIMER_A_CLK_EN <= idle_or_active && !gates_q[BIT_GATE_TIMER_A];
            TIMER_B_CLK_EN <= idle_or_active && !gates_q[BIT_GATE_TIMER_B];
            SERIAL_CLK_EN  <= idle_or_active && !gates_q[BIT_GATE_SERIAL];
            ADC_CLK_EN     <= !deep && !gates_q[BIT_GATE_CONV];
            PERIPH_ACC_BLOCK_T_A <= gates_q[BIT_GATE_TIMER_A];
            ACMP_MUX_BLOCK <= gates_q[BIT_GATE_CONV];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ADC_AUTO_START <= 1'b0;
            ADC_EXTENDED   <= 1'b1;
        end else begin
            ADC_AUTO_START <= state_q == ST_ACTIVE && armed && ADC_EN
                              && (sel == SEL_NOISE || sel == SEL_IDLE);
            if (!ADC_EN) begin
                ADC_EXTENDED <= 1'b1;
            end else if (ADC_AUTO_START) begin
                ADC_EXTENDED <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ACMP_DISABLE   <= 1'b0;
            BOD_ON         <= 1'b0;
            WDT_RUN        <= 1'b0;
            INBUF_DISABLE  <= 1'b0;
            PULLUP_DISABLE <= 1'b0;
            CORE_RUN       <= 1'b1;
            IRQ_SERVICE    <= 1'b0;
        end else begin
            ACMP_DISABLE   <= deep && !ACMP_BANDGAP;
            BOD_ON         <= BOD_FUSE;
            WDT_RUN        <= WDT_EN;
            INBUF_DISABLE  <= deep;
            PULLUP_DISABLE <= ctrl_q[BIT_PULLUP_DIS];
            CORE_RUN       <= !asleep && state_q != ST_HALT && state_q != ST_START;
            IRQ_SERVICE    <= state_q == ST_HALT
                              && cnt_q == 4'(WAKE_HALT_CYCLES - 1);
        end
    end

    assign RDATA = rdata_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_arm_required: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && SLEEP_REQ && !ctrl_q[BIT_SLEEP_ARM]) |=> state_q == ST_ACTIVE)
        else $error("sleep entered without arm bit");
    a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        ctrl_q[2] == 1'b0)
        else $error("reserved control bit set");
    a_standby_resume: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_STANDBY && wake_ok(mode_q, wake_s2_q))
        |-> ##[1:6] CLK_EN.cpu)
        else $error("standby wake too slow");
    a_pdown_osc_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_PDOWN) |=> !CLK_EN.osc && !CLK_EN.adc)
        else $error("power-down clocks running");
    a_noise_clocks: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_NOISE) |=> !CLK_EN.io && CLK_EN.adc)
        else $error("noise mode clocks wrong");
    a_halt_four: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(state_q == ST_HALT) |-> (state_q == ST_HALT) [*4] ##1 state_q == ST_ACTIVE)
        else $error("halt not four cycles");
    a_gate_timer: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        gates_q[BIT_GATE_TIMER_A] |=> !TIMER_A_CLK_EN)
        else $error("gated timer clock running");
    a_inbuf_deep: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q[1]) |=> INBUF_DISABLE)
        else $error("input buffers left on");
    a_acmp_bandgap: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        ACMP_BANDGAP |=> !ACMP_DISABLE)
        else $error("comparator disabled with bandgap");
    a_idle_clocks: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_IDLE) |=> !CLK_EN.cpu && !CLK_EN.flash
        && CLK_EN.io && CLK_EN.adc && CLK_EN.osc)
        else $error("idle clocks wrong");
    a_noise_osc: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_NOISE) |=> !CLK_EN.cpu && !CLK_EN.flash && CLK_EN.osc)
        else $error("noise mode core clocks wrong");
    a_standby_osc: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_STANDBY) |=> CLK_EN.osc && !CLK_EN.adc)
        else $error("standby clocks wrong");
    a_pdown_io: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_PDOWN) |=> !CLK_EN.io && !CLK_EN.cpu)
        else $error("power-down core clocks running");
    a_noise_enter: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && armed && sel == SEL_NOISE)
        |=> state_q == ST_SLEEP && mode_q == SEL_NOISE)
        else $error("noise mode not entered");
    a_pdown_enter: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && armed && sel == SEL_PDOWN)
        |=> state_q == ST_SLEEP && mode_q == SEL_PDOWN)
        else $error("power-down not entered");
    a_idle_enter: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && armed && sel == SEL_IDLE)
        |=> state_q == ST_SLEEP && mode_q == SEL_IDLE)
        else $error("idle not entered");
    a_standby_xtal: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && SLEEP_REQ && ctrl_q[BIT_SLEEP_ARM] && sel == SEL_STANDBY
        && !XTAL_SEL) |=> state_q == ST_ACTIVE)
        else $error("standby entered without crystal");
    a_mode_latch: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && !wake_ok(mode_q, wake_s2_q)) |=> state_q == ST_SLEEP && $stable(mode_q))
        else $error("sleep mode not held");
    a_wake_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && wake_ok(mode_q, wake_s2_q)) |=> state_q == ST_START)
        else $error("permitted wake ignored");
    a_noise_ignore: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_NOISE && !wake_s2_q.adc_done && !wake_s2_q.spm_ready
        && !wake_s2_q.ext_irq_zero_lvl && !wake_s2_q.pin_change && !wake_s2_q.wdt_irq)
        |=> state_q == ST_SLEEP)
        else $error("noise mode woken by other source");
    a_noise_adc_wake: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_NOISE && wake_s2_q.adc_done) |=> state_q == ST_START)
        else $error("conversion done did not wake");
    a_pdown_ignore: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q[1] && !wake_s2_q.ext_irq_zero_lvl && !wake_s2_q.pin_change
        && !wake_s2_q.wdt_irq) |=> state_q == ST_SLEEP)
        else $error("deep sleep woken by other source");
    a_pdown_wake: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_PDOWN && wake_s2_q.pin_change) |=> state_q == ST_START)
        else $error("pin change did not wake");
    a_standby_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_START && mode_q == SEL_STANDBY) |=> state_q == ST_HALT)
        else $error("standby start-up too long");
    a_auto_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && armed && ADC_EN && sel == SEL_NOISE) |=> ADC_AUTO_START)
        else $error("conversion not started");
    a_no_auto_deep: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_ACTIVE && armed && sel[1]) |=> !ADC_AUTO_START)
        else $error("conversion started in deep sleep");
    a_extended_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !ADC_EN |=> ADC_EXTENDED)
        else $error("extended conversion not flagged");
    a_adc_asleep: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q == SEL_NOISE && !gates_q[BIT_GATE_CONV]) |=> ADC_CLK_EN)
        else $error("adc clock stopped in noise mode");
    a_deep_acmp: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q[1] && !ACMP_BANDGAP) |=> ACMP_DISABLE)
        else $error("comparator left on in deep sleep");
    a_bod_follow: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        BOD_FUSE |=> BOD_ON)
        else $error("brown-out detector off");
    a_wdt_follow: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        WDT_EN |=> WDT_RUN)
        else $error("watchdog stopped");
    a_inbuf_awake: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !(state_q == ST_SLEEP && mode_q[1]) |=> !INBUF_DISABLE)
        else $error("input buffers off while clocked");
    a_gate_access: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !gates_q[BIT_GATE_TIMER_A] |=> !PERIPH_ACC_BLOCK_T_A)
        else $error("timer access blocked while ungated");
    a_ungate_timer: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (!gates_q[BIT_GATE_TIMER_B] && !asleep) |=> TIMER_B_CLK_EN)
        else $error("ungated timer clock stopped");
    a_gate_deep: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_q == ST_SLEEP && mode_q != SEL_IDLE) |=> !TIMER_A_CLK_EN && !SERIAL_CLK_EN)
        else $error("peripheral clock running in deep sleep");
    a_serial_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        gates_q[BIT_GATE_SERIAL] |=> !SERIAL_CLK_EN)
        else $error("gated serial clock running");
    a_gate_reserved: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        gates_q[7:4] == 4'h0)
        else $error("reserved gate bits set");
    a_mux_block: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        gates_q[BIT_GATE_CONV] |=> ACMP_MUX_BLOCK && !ADC_CLK_EN)
        else $error("gated adc mux still usable");
    a_core_halted: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_q == ST_HALT |=> !CORE_RUN)
        else $error("core running during wake halt");

endmodule
`default_nettype wire

// ===== tb/smc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// core and wake-source side of the sleep controller
// ---------------------------------------------------------------
module smc_core_model
    import smc_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rstn,
    input  wire logic      sleep_go,
    input  wire smc_wake_t wake_set,
    output logic           sleep_req,
    output smc_wake_t      wake
);
    // sleep instruction registered into the request one cycle later
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sleep_req <= 1'b0;
        end else begin
            sleep_req <= sleep_go;
        end
    end

    // wake levels held for as long as the source asks
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wake <= '0;
        end else begin
            wake <= wake_set;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import smc_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rstn, wr, rd, sleep_go, sleep_req, xtal_sel, adc_en, bod_fuse, wdt_en, acmp_bg;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, rv;
    smc_wake_t  wake_set, wake, bad;
    smc_clk_t   clk_en;
    logic       t_a_en, t_b_en, ser_en, adc_clk_en, acc_blk, auto_start, adc_ext;
    logic       acmp_dis, mux_blk, bod_on, wdt_run, inbuf_dis, pu_dis, core_run, irq_srv;
    int         n_errors, num_checks, cyc, n_start, s0, n;

    smc_sleep_ctrl #(.START_CYCLES(2)) i_dut (
        .CORE_CLK(core_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SLEEP_REQ(sleep_req), .WAKE(wake), .XTAL_SEL(xtal_sel),
        .ADC_EN(adc_en), .ACMP_BANDGAP(acmp_bg), .BOD_FUSE(bod_fuse), .WDT_EN(wdt_en),
        .CLK_EN(clk_en), .TIMER_A_CLK_EN(t_a_en), .TIMER_B_CLK_EN(t_b_en),
        .SERIAL_CLK_EN(ser_en), .ADC_CLK_EN(adc_clk_en), .PERIPH_ACC_BLOCK_T_A(acc_blk),
        .ADC_AUTO_START(auto_start), .ADC_EXTENDED(adc_ext), .ACMP_DISABLE(acmp_dis),
        .ACMP_MUX_BLOCK(mux_blk), .BOD_ON(bod_on), .WDT_RUN(wdt_run),
        .INBUF_DISABLE(inbuf_dis), .PULLUP_DISABLE(pu_dis), .CORE_RUN(core_run),
        .IRQ_SERVICE(irq_srv)
    );

    smc_core_model i_core (
        .core_clk(core_clk), .rstn(rstn), .sleep_go(sleep_go), .wake_set(wake_set),
        .sleep_req(sleep_req), .wake(wake)
    );

    // ---------------------------------------------------------------
    // clock, timeout and auto-start counting
    // ---------------------------------------------------------------
    always #4 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (auto_start === 1'b1) begin
            n_start = n_start + 1;
        end
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // software arms right before the sleep instruction
    task automatic go_sleep(input logic [7:0] ctrl);
        wr_reg(ADR_PWR_CTRL, ctrl);
        @(posedge core_clk);
        sleep_go <= 1'b1;
        @(posedge core_clk);
        sleep_go <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {rstn, wr, rd, sleep_go, xtal_sel, adc_en, bod_fuse, wdt_en, acmp_bg} = 9'h000;
        {addr, wdata, wake_set} = '0;
        {n_errors, num_checks, cyc, n_start} = '0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd_reg(ADR_PWR_CTRL, rv);  chk("ctrl reset", rv, 8'h00);
        rd_reg(ADR_PWR_GATES, rv); chk("gates reset", rv, 8'h00);
        rd_reg(2'h3, rv);          chk("unmapped", rv, 8'h00);
        wr_reg(ADR_PWR_CTRL, 8'hff);
        rd_reg(ADR_PWR_CTRL, rv);  chk("ctrl mask", rv, 8'hfb);
        chk("pullup", {7'h0, pu_dis}, 8'h01);
        wr_reg(ADR_PWR_CTRL, 8'h00);
        wr_reg(ADR_PWR_GATES, 8'hff);
        rd_reg(ADR_PWR_GATES, rv); chk("gates mask", rv, 8'h0f);
        chk("gated", {3'h0, t_b_en, t_a_en, ser_en, adc_clk_en, acc_blk}, 8'h01);
        chk("mux block", {7'h0, mux_blk}, 8'h01);
        wr_reg(ADR_PWR_GATES, 8'h00);
        @(posedge core_clk);
        #1;
        chk("ungated", {3'h0, t_b_en, t_a_en, ser_en, adc_clk_en, acc_blk}, 8'h1e);
        {adc_en, bod_fuse, wdt_en} <= 3'b111;
        repeat (2) @(posedge core_clk);
        chk("adc extended", {7'h0, adc_ext}, 8'h01);
        // unarmed request and standby without crystal are refused
        go_sleep(8'h08);
        chk("unarmed", {6'h0, core_run, clk_en.cpu}, 8'h03);
        go_sleep(8'h38);
        chk("no xtal", {6'h0, core_run, clk_en.cpu}, 8'h03);
        xtal_sel <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            s0 = n_start;
            acmp_bg <= (m == 3);
            go_sleep({2'b00, 1'b1, m[1:0], 3'b000});
            chk("clocks", {3'h0, clk_en}, {5'h0, m == 0, m <= 1, m != 2});
            chk("deep", {4'h0, acmp_dis, inbuf_dis, bod_on, wdt_run}, {4'h0, m == 2, m >= 2, 2'b11});
            chk("adc run", {7'h0, adc_clk_en}, {7'h0, m <= 1});
            chk("auto start", {7'h0, n_start > s0}, {7'h0, m <= 1});
            rd_reg(ADR_STATUS, rv);
            chk("status", rv, {3'h0, m[1:0], ST_SLEEP});
            if (m > 0) begin
                bad = '0;
                if (m == 1) begin
                    bad.other_io = 1'b1;
                end else begin
                    bad.adc_done = 1'b1;
                end
                wake_set <= bad;
                repeat (12) @(posedge core_clk);
                #1;
                chk("no wake", {7'h0, core_run}, 8'h00);
                wake_set <= '0;
                repeat (3) @(posedge core_clk);
            end
            wake_set.pin_change <= 1'b1;
            n = 0;
            do begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end while (clk_en.cpu !== 1'b1 && n < 40);
            if (m == 3) begin
                chk("standby wake", {7'h0, n <= STANDBY_WAKE_CYCLES}, 8'h01);
            end
            n = 0;
            while (irq_srv !== 1'b1 && n < 60) begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            chk("irq service", {7'h0, irq_srv}, 8'h01);
            @(posedge core_clk);
            #1;
            chk("core run", {7'h0, core_run}, 8'h01);
            wake_set <= '0;
            wr_reg(ADR_PWR_CTRL, 8'h00);
            repeat (3) @(posedge core_clk);
        end
        #1;
        chk("adc ext cleared", {7'h0, adc_ext}, 8'h00);
        @(posedge core_clk);
        adc_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("adc ext again", {7'h0, adc_ext}, 8'h01);
        summarize();
    end
endmodule
`default_nettype wire
